// ===== hw/gtpg_params.svh
// Notes on behaviour
// - A write to the test-mode control register picks mode 1, 2, 4, 5, 6 or 7 from codes 0x2000, 0x4000, 0x8000, 0xa000, 0xc000 and 0xe000.
// - Mode 1 derives a test clock at one sixth of the symbol clock and drives it on the clock output pin.
// - Mode 2 sends three +1 symbols then three -1 symbols, over and over.
// - Mode 4 runs a scrambler with polynomial 1 + x^9 + x^11.
// - Mode 4 takes bit 0 = scr[0], bit 1 = scr[1]^scr[4], bit 2 = scr[1]^scr[5].
// - Mode 4 maps each 3-bit value to a ternary symbol pair with the fixed eight-entry table.
// - Mode 5 sends the ordinary scrambled idle symbol stream.
// - Mode 6 sends fifteen +1 then fifteen -1 symbols until the mode is left.
// - Mode 7 sends the same scrambled symbol stream as mode 4 and counts every received one bit as an error.
// - Mode 7 compares only data that has passed error correction and block decoding.
// - The test clock can be driven on any one of three general-purpose pins.
`ifndef GTPG_PARAMS_SVH
`define GTPG_PARAMS_SVH

`define GTPG_IDX_ROUTE     14'h0453
`define GTPG_IDX_MODE      14'h0904
`define GTPG_IDX_GPIO_SEL  14'h0910
`define GTPG_IDX_ERR_COUNT 14'h0911
`define GTPG_IDX_STATUS    14'h0912

`define GTPG_MODE1_CODE    16'h2000
`define GTPG_MODE2_CODE    16'h4000
`define GTPG_MODE4_CODE    16'h8000
`define GTPG_MODE5_CODE    16'ha000
`define GTPG_MODE6_CODE    16'hc000
`define GTPG_MODE7_CODE    16'he000
`define GTPG_ROUTE_CLKOUT  16'h0019

`define GTPG_MODE_RESET    16'h0000
`define GTPG_ROUTE_RESET   16'h0000
`define GTPG_SCR_SEED      11'h7ff

`define GTPG_DIV_HALF      2'h3
`define GTPG_PERIOD_SHORT  5'h06
`define GTPG_PERIOD_LONG   5'h1e

`define GTPG_SYM_ZERO      2'h0
`define GTPG_SYM_PLUS      2'h1
`define GTPG_SYM_MINUS     2'h3

`define GTPG_RESP_OKAY     2'h0
`define GTPG_RESP_SLVERR   2'h2

`endif

// ===== hw/gtpg_pkg.sv
`default_nettype none
package gtpg_pkg;

  typedef enum logic [2:0] {
    gtpg_off,
    gtpg_mode1,
    gtpg_mode2,
    gtpg_mode4,
    gtpg_mode5,
    gtpg_mode6,
    gtpg_mode7
  } gtpg_mode_t;

  typedef struct packed {
    logic             aw_full;
    logic [13:0]      aw_idx;
    logic             w_full;
    logic [15:0]      w_data;
    logic [1:0]       w_strb;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
    logic [15:0]      mode_code;
    gtpg_mode_t       mode;
    logic [15:0]      route;
    logic [1:0]       gpio_sel;
    logic [31:0]      err_count;
    logic [10:0]      scr;
    logic [4:0]       phase;
    logic [1:0]       div_cnt;
    logic             div_clk;
    logic             clkout;
    logic [2:0]       gpio_out;
    logic [2:0]       gpio_oe;
  } gtpg_state_t;

endpackage
`default_nettype wire

// ===== hw/gtpg_top.sv
// The AXI4-Lite register port was chosen for this implementation.
`include "gtpg_params.svh"
`default_nettype none

////////////////////////////////////////////////////////////////////////////////

module gtpg_fifo
#(
  parameter int WIDTH = 4,
  parameter int DEPTH = 8
)
(
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               rd;
    logic [AW-1:0]               wr;
    logic [AW:0]                 count;
  } gtpg_fifo_state_t;

  gtpg_fifo_state_t st;
  gtpg_fifo_state_t next_st;
  logic             push;
  logic             pop;

  assign in_ready  = (32'(st.count) != DEPTH);
  assign out_valid = (st.count != '0);
  assign out_data  = st.mem[st.rd];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb
  begin
    next_st = st;
    if (push)
    begin
      next_st.mem[st.wr] = in_data;
      next_st.wr = (32'(st.wr) == DEPTH - 1) ? '0 : st.wr + 1'b1;
    end
    if (pop)
      next_st.rd = (32'(st.rd) == DEPTH - 1) ? '0 : st.rd + 1'b1;
    if (push && !pop)
      next_st.count = st.count + 1'b1;
    else if (pop && !push)
      next_st.count = st.count - 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st <= '0;
    else
      st <= next_st;
  end

endmodule

////////////////////////////////////////////////////////////////////////////////

module gtpg_top
  import gtpg_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
)
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [15:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [15:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        tx_in_valid,
  input  wire logic [3:0]  tx_in_pair,
  output logic             tx_in_ready,
  output logic             tx_sym_valid,
  output logic [3:0]       tx_sym_pair,
  input  wire logic        tx_sym_ready,
  input  wire logic        rx_decoded_valid,
  input  wire logic [7:0]  rx_decoded_data,
  output logic             clkout_test,
  output logic [2:0]       gpio_test_out,
  output logic [2:0]       gpio_test_oe
);

  gtpg_state_t st;
  gtpg_state_t next_st;
  logic        gen_valid;
  logic [3:0]  gen_pair;
  logic        fifo_in_ready;
  logic        gen_step;
  logic        do_write;
  logic        clk_to_pin;

  //////////////////////////////////////////////////////////////////////////////

  // Ternary symbol pair {high, low} for one 3-bit scrambler value.
  function automatic logic [3:0] map_pair(input logic [2:0] x);
    logic [3:0] p;
    unique case (x)
      3'h0: p = {`GTPG_SYM_MINUS, `GTPG_SYM_MINUS};
      3'h1: p = {`GTPG_SYM_ZERO,  `GTPG_SYM_MINUS};
      3'h2: p = {`GTPG_SYM_MINUS, `GTPG_SYM_ZERO};
      3'h3: p = {`GTPG_SYM_MINUS, `GTPG_SYM_PLUS};
      3'h4: p = {`GTPG_SYM_PLUS,  `GTPG_SYM_ZERO};
      3'h5: p = {`GTPG_SYM_PLUS,  `GTPG_SYM_MINUS};
      3'h6: p = {`GTPG_SYM_PLUS,  `GTPG_SYM_PLUS};
      3'h7: p = {`GTPG_SYM_ZERO,  `GTPG_SYM_PLUS};
    endcase
    return p;
  endfunction

  // Square-wave symbol for position ph of a period of per symbols.
  function automatic logic [1:0] square(input logic [4:0] ph,
                                        input logic [4:0] per);
    return (ph < (per >> 1)) ? `GTPG_SYM_PLUS : `GTPG_SYM_MINUS;
  endfunction

  function automatic gtpg_mode_t decode_mode(input logic [15:0] code);
    gtpg_mode_t m;
    unique case (code)
      `GTPG_MODE1_CODE: m = gtpg_mode1;
      `GTPG_MODE2_CODE: m = gtpg_mode2;
      `GTPG_MODE4_CODE: m = gtpg_mode4;
      `GTPG_MODE5_CODE: m = gtpg_mode5;
      `GTPG_MODE6_CODE: m = gtpg_mode6;
      `GTPG_MODE7_CODE: m = gtpg_mode7;
      default:          m = gtpg_off;
    endcase
    return m;
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] val,
                                        input logic [1:0]  strb);
    return {strb[1] ? val[15:8] : old[15:8], strb[0] ? val[7:0] : old[7:0]};
  endfunction

  //////////////////////////////////////////////////////////////////////////////

  // Pattern source: each word is one symbol pair, high symbol sent first.
  always_comb
  begin
    logic [4:0]  per;
    logic [4:0]  ph1;
    logic [2:0]  bits;
    per = `GTPG_PERIOD_SHORT;
    ph1 = 5'h0;
    bits = {st.scr[1] ^ st.scr[5], st.scr[1] ^ st.scr[4], st.scr[0]};
    gen_valid = 1'b1;
    gen_pair = map_pair(bits);
    if (st.mode == gtpg_mode6)
      per = `GTPG_PERIOD_LONG;
    ph1 = st.phase + 5'h1;
    unique case (st.mode)
      gtpg_off:
      begin
        gen_valid = tx_in_valid;
        gen_pair = tx_in_pair;
      end
      gtpg_mode2, gtpg_mode6:
        gen_pair = {square(st.phase, per), square(ph1, per)};
      default:
      begin
      end
    endcase
  end

  assign gen_step    = gen_valid && fifo_in_ready;
  assign tx_in_ready = (st.mode == gtpg_off) && fifo_in_ready;

  gtpg_fifo
  #(
    .WIDTH (4),
    .DEPTH (FIFO_DEPTH)
  )
  gtpg_fifo_inst
  (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (gen_valid),
    .in_data   (gen_pair),
    .in_ready  (fifo_in_ready),
    .out_valid (tx_sym_valid),
    .out_data  (tx_sym_pair),
    .out_ready (tx_sym_ready)
  );

  //////////////////////////////////////////////////////////////////////////////

  assign do_write   = st.aw_full && st.w_full && !st.bvalid;
  assign clk_to_pin = (st.mode == gtpg_mode1) ||
                      (st.mode == gtpg_mode4 &&
                       st.route == `GTPG_ROUTE_CLKOUT);

  always_comb
  begin
    logic [5:0]  ones;
    logic [13:0] ridx;
    logic [31:0] rval;
    logic        rhit;
    logic [4:0]  per;
    ones = '0;
    ridx = s_axi_araddr[15:2];
    rval = '0;
    rhit = 1'b1;
    per = (st.mode == gtpg_mode6) ? `GTPG_PERIOD_LONG : `GTPG_PERIOD_SHORT;
    next_st = st;

    // Write address and data are taken in either order and held.
    if (s_axi_awvalid && !st.aw_full)
    begin
      next_st.aw_full = 1'b1;
      next_st.aw_idx = s_axi_awaddr[15:2];
    end
    if (s_axi_wvalid && !st.w_full)
    begin
      next_st.w_full = 1'b1;
      next_st.w_data = s_axi_wdata[15:0];
      next_st.w_strb = s_axi_wstrb[1:0];
    end
    if (st.bvalid && s_axi_bready)
      next_st.bvalid = 1'b0;

    // Mode 7 error counter; a clearing write zeroes the old count and a same-cycle count is added on top.
    if (st.mode == gtpg_mode7 && rx_decoded_valid)
    begin
      for (int i = 0; i < 8; i++)
        ones = ones + {5'h0, rx_decoded_data[i]};
    end

    // A mode write restarts the phase, so the generator step comes first.
    if (gen_step && st.mode != gtpg_off)
    begin
      next_st.scr = {st.scr[9:0], st.scr[8] ^ st.scr[10]};
      next_st.phase = (st.phase + 5'h2 >= per) ? 5'h0 : st.phase + 5'h2;
    end

    if (do_write)
    begin
      next_st.aw_full = 1'b0;
      next_st.w_full = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = `GTPG_RESP_OKAY;
      unique case (st.aw_idx)
        `GTPG_IDX_MODE:
        begin
          next_st.mode_code = merge(st.mode_code, st.w_data, st.w_strb);
          next_st.mode = decode_mode(next_st.mode_code);
          next_st.phase = '0;
        end
        `GTPG_IDX_ROUTE:
          next_st.route = merge(st.route, st.w_data, st.w_strb);
        `GTPG_IDX_GPIO_SEL:
          if (st.w_strb[0])
            next_st.gpio_sel = st.w_data[1:0];
        `GTPG_IDX_ERR_COUNT:
          next_st.err_count = '0;
        `GTPG_IDX_STATUS:
        begin
        end
        default:
          next_st.bresp = `GTPG_RESP_SLVERR;
      endcase
    end
    if (ones != '0 && st.err_count != 32'hffffffff)
      next_st.err_count = next_st.err_count + {26'h0, ones};

    // Read port: one read under way, answered in the cycle after arvalid.
    if (st.rvalid && s_axi_rready)
      next_st.rvalid = 1'b0;
    unique case (ridx)
      `GTPG_IDX_MODE:      rval = {16'h0, st.mode_code};
      `GTPG_IDX_ROUTE:     rval = {16'h0, st.route};
      `GTPG_IDX_GPIO_SEL:  rval = {30'h0, st.gpio_sel};
      `GTPG_IDX_ERR_COUNT: rval = st.err_count;
      `GTPG_IDX_STATUS:    rval = {28'h0, clk_to_pin, st.mode};
      default:             rhit = 1'b0;
    endcase
    if (s_axi_arvalid && !st.rvalid)
    begin
      next_st.rvalid = 1'b1;
      next_st.rdata = rval;
      next_st.rresp = rhit ? `GTPG_RESP_OKAY : `GTPG_RESP_SLVERR;
    end

    // Divide by six: toggle every third cycle.
    if (st.div_cnt == `GTPG_DIV_HALF - 2'h1)
    begin
      next_st.div_cnt = '0;
      next_st.div_clk = !st.div_clk;
    end
    else
      next_st.div_cnt = st.div_cnt + 2'h1;
    next_st.clkout = clk_to_pin && next_st.div_clk;
    next_st.gpio_oe = '0;
    next_st.gpio_out = '0;
    if (st.gpio_sel != 2'h0 && st.mode != gtpg_off)
    begin
      next_st.gpio_oe[st.gpio_sel - 2'h1] = 1'b1;
      next_st.gpio_out[st.gpio_sel - 2'h1] = next_st.div_clk;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st <= '0;
      st.mode_code <= `GTPG_MODE_RESET;
      st.route <= `GTPG_ROUTE_RESET;
      st.mode <= gtpg_off;
      st.scr <= `GTPG_SCR_SEED;
    end
    else
      st <= next_st;
  end

  //////////////////////////////////////////////////////////////////////////////

  assign s_axi_awready = !st.aw_full;
  assign s_axi_wready  = !st.w_full;
  assign s_axi_bvalid  = st.bvalid;
  assign s_axi_bresp   = st.bresp;
  assign s_axi_arready = !st.rvalid;
  assign s_axi_rvalid  = st.rvalid;
  assign s_axi_rdata   = st.rdata;
  assign s_axi_rresp   = st.rresp;
  assign clkout_test   = st.clkout;
  assign gpio_test_out = st.gpio_out;
  assign gpio_test_oe  = st.gpio_oe;

endmodule

`default_nettype wire

// ===== sim/gtpg_checker_asserts.sv
`default_nettype none

module gtpg_checker
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        tx_sym_valid,
  input wire logic [3:0]  tx_sym_pair,
  input wire logic        tx_sym_ready,
  input wire logic        clkout_test,
  input wire logic [2:0]  gpio_test_oe
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp moved");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read response late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  a_sym_hold: assert property (tx_sym_valid && !tx_sym_ready
    |=> tx_sym_valid && $stable(tx_sym_pair)) else $error("symbol moved");
  a_ternary_code: assert property (
    tx_sym_valid |-> tx_sym_pair[3:2] != 2'h2 && tx_sym_pair[1:0] != 2'h2)
    else $error("bad symbol code");
  a_clock_high: assert property (
    $rose(clkout_test) ##1 clkout_test [*2] |=> !clkout_test)
    else $error("test clock high too long");
  a_gpio_single: assert property ($onehot0(gpio_test_oe))
    else $error("several gpio driven");
endmodule

bind gtpg_top gtpg_checker gtpg_checker_inst (.*);

`default_nettype wire

// ===== sim/gtpg_line_partner.sv
`default_nettype none

module gtpg_line_partner
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       stall,
  input  wire logic       tx_sym_valid,
  input  wire logic [3:0] tx_sym_pair,
  output logic            tx_sym_ready,
  output logic            rx_decoded_valid,
  output logic [7:0]      rx_decoded_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] got [$];
  logic [1:0] cnt = 2'h0;

  initial
  begin
    tx_sym_ready = 1'b0;
    rx_decoded_valid = 1'b0;
    rx_decoded_data = 8'h00;
  end

  // Ready drops every fourth cycle so the generator always meets stalls.
  always @(posedge aclk)
  begin
    cnt <= cnt + 2'h1;
    if (tx_sym_valid && tx_sym_ready)
      got.push_back(tx_sym_pair);
    tx_sym_ready <= aresetn && !stall && cnt != 2'h3;
  end

  task automatic send(input logic [7:0] b, input logic v);
    rx_decoded_data <= b;
    rx_decoded_valid <= v;
    @(posedge aclk);
    rx_decoded_valid <= 1'b0;
    rx_decoded_data <= ~b;
    @(posedge aclk);
  endtask
endmodule

`default_nettype wire

// ===== sim/tb_gigabit_t1_test_pattern_gen.sv
`default_nettype none

module tb_gigabit_t1_test_pattern_gen;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 0, aresetn = 0, stall = 0;
  logic [15:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [3:0]  wstrb = 4'hf, tx_in_pair = 0, pair;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
  logic        rready = 0, tx_in_valid = 0;
  logic        awready, wready, bvalid, arready, rvalid, tx_in_ready;
  logic        tx_sym_valid, tx_sym_ready, rx_v, clkout;
  logic [1:0]  bresp, rresp;
  logic [7:0]  rx_d;
  logic [2:0]  gpo, gpoe;
  int          mismatches = 0, compares = 0;
  logic [3:0]  pv [9] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h5, 4'h7, 4'hc, 4'hd,
                          4'hf};
  logic [3:0]  mp [8] = '{4'hf, 4'h3, 4'hc, 4'hd, 4'h4, 4'h7, 4'h5, 4'h1};

  gtpg_top gtpg_top_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .tx_in_valid(tx_in_valid),
    .tx_in_pair(tx_in_pair), .tx_in_ready(tx_in_ready),
    .tx_sym_valid(tx_sym_valid), .tx_sym_pair(pair),
    .tx_sym_ready(tx_sym_ready), .rx_decoded_valid(rx_v),
    .rx_decoded_data(rx_d), .clkout_test(clkout), .gpio_test_out(gpo),
    .gpio_test_oe(gpoe));

  gtpg_line_partner gtpg_line_partner_inst (.aclk(aclk), .aresetn(aresetn),
    .stall(stall), .tx_sym_valid(tx_sym_valid), .tx_sym_pair(pair),
    .tx_sym_ready(tx_sym_ready), .rx_decoded_valid(rx_v),
    .rx_decoded_data(rx_d));

  always #20 aclk = ~aclk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic ta, tw, tb;
    tb = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    repeat (50)
    begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      @(posedge aclk);
      if (ta) awvalid <= 0;
      if (tw) wvalid <= 0;
      if (tb)
      begin
        bready <= 0;
        check(bresp, er);
        break;
      end
    end
    if (!tb)
      check({31'h0, tb}, 32'h1);
    @(posedge aclk);
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    logic t, s;
    s = 0;
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    repeat (50)
    begin
      @(negedge aclk);
      t = arvalid && arready;
      s = rvalid;
      @(posedge aclk);
      if (t) arvalid <= 0;
      if (s)
      begin
        rready <= 0;
        check(rdata, ed);
        check(rresp, er);
        break;
      end
    end
    if (!s)
      check({31'h0, s}, 32'h1);
    @(posedge aclk);
  endtask

  task automatic drain();
    wr(16'h2410, 32'h0, 2'h0);
    repeat (30) @(posedge aclk);
    gtpg_line_partner_inst.got.delete();
    repeat (10) @(posedge aclk);
    check(gtpg_line_partner_inst.got.size(), 0);
  endtask

  function automatic logic [1:0] sy(int i, int h);
    return (i % (2 * h)) < h ? 2'h1 : 2'h3;
  endfunction

  task automatic t_regs();
    logic [15:0] codes [6] = '{16'h2000, 16'h4000, 16'h8000, 16'ha000,
                               16'hc000, 16'he000};
    rd(16'h2410, 32'h0, 2'h0);
    rd(16'h114c, 32'h0, 2'h0);
    wr(16'h114c, 32'h19, 2'h0);
    rd(16'h114c, 32'h19, 2'h0);
    rd(16'h0100, 32'h0, 2'h2);
    wr(16'h0100, 32'h5, 2'h2);
    for (int i = 0; i < 6; i++)
    begin
      wr(16'h2410, {16'h0, codes[i]}, 2'h0);
      rd(16'h2448,
         32'(i + 1) | ((i == 0 || i == 2) ? 32'h8 : 32'h0),
         2'h0);
    end
    wr(16'h2410, 32'h1234, 2'h0);
    rd(16'h2448, 32'h0, 2'h0);
    wr(16'h114c, 32'h0, 2'h0);
    drain();
  endtask

  task automatic t_fifo();
    logic t;
    int n;
    n = 0;
    stall <= 1;
    repeat (12)
    begin
      tx_in_valid <= 1;
      tx_in_pair <= pv[n];
      @(negedge aclk);
      t = tx_in_ready;
      @(posedge aclk);
      if (t) n++;
    end
    tx_in_valid <= 0;
    check(n, 8);
    stall <= 0;
    repeat (30) @(posedge aclk);
    for (int k = 0; k < 8; k++)
      check(gtpg_line_partner_inst.got[k], pv[k]);
    drain();
  endtask

  task automatic t_pattern(input logic [15:0] code, input int h);
    wr(16'h2410, {16'h0, code}, 2'h0);
    repeat (60) @(posedge aclk);
    for (int k = 0; k < 30; k++)
      check(gtpg_line_partner_inst.got[k],
            {sy(2 * k, h), sy(2 * k + 1, h)});
    drain();
  endtask

  task automatic t_scrambler(input logic [15:0] code);
    logic [10:0] sc;
    logic [2:0]  x;
    logic        ok, hit;
    hit = 0;
    wr(16'h2410, {16'h0, code}, 2'h0);
    repeat (40) @(posedge aclk);
    for (int s = 0; s < 2048; s++)
    begin
      sc = 11'(s);
      ok = 1;
      for (int k = 0; k < 20; k++)
      begin
        x = {sc[1] ^ sc[5], sc[1] ^ sc[4], sc[0]};
        if (gtpg_line_partner_inst.got[k] !== mp[x]) ok = 0;
        sc = {sc[9:0], sc[8] ^ sc[10]};
      end
      if (ok) hit = 1;
    end
    check(hit, 1);
    drain();
  endtask

  task automatic rises(input int w, input int exp);
    logic v, p;
    int c;
    c = 0;
    p = 1;
    // One sample more than ten periods, so any phase shows ten rises.
    repeat (61)
    begin
      @(negedge aclk);
      v = (w == 3) ? clkout : gpo[w];
      if (v && !p) c++;
      p = v;
    end
    check(c, exp);
  endtask

  task automatic t_clock();
    wr(16'h2410, 32'h8000, 2'h0);
    rises(3, 0);
    wr(16'h114c, 32'h19, 2'h0);
    rd(16'h2448, 32'hb, 2'h0);
    rises(3, 10);
    wr(16'h2410, 32'h2000, 2'h0);
    rises(3, 10);
    for (int g = 1; g < 4; g++)
    begin
      wr(16'h2440, 32'(g), 2'h0);
      rises(g - 1, 10);
      check(gpoe, 3'h1 << (g - 1));
    end
    drain();
  endtask

  task automatic t_errors();
    wr(16'h2410, 32'he000, 2'h0);
    wr(16'h2444, 32'h0, 2'h0);
    gtpg_line_partner_inst.send(8'h00, 1);
    gtpg_line_partner_inst.send(8'h81, 1);
    gtpg_line_partner_inst.send(8'h55, 0);
    gtpg_line_partner_inst.send(8'hff, 1);
    rd(16'h2444, 32'ha, 2'h0);
    wr(16'h2410, 32'ha000, 2'h0);
    gtpg_line_partner_inst.send(8'hff, 1);
    rd(16'h2444, 32'ha, 2'h0);
    drain();
  endtask

  task automatic stop_test();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    t_regs();
    t_fifo();
    t_pattern(16'h4000, 3);
    t_pattern(16'hc000, 15);
    t_scrambler(16'h8000);
    t_scrambler(16'ha000);
    t_clock();
    t_errors();
    stop_test();
  end

  initial
  begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    stop_test();
  end
endmodule

`default_nettype wire
